// ---- prcd_pkg.sv ----
// constants, types and decode function for the phase resistance code decoder
package prcd_pkg;

   // ---------------------------------------------------------------
   // code layout
   // ---------------------------------------------------------------
   localparam int CODE_W = 7;
   localparam int EXP_W = 3;
   localparam int MANT_W = 4;
   localparam int EXP_MSB = 6;
   localparam int EXP_LSB = 4;
   localparam int MANT_MSB = 3;
   localparam int MANT_LSB = 0;
   localparam logic [6:0] CODE_RESET = 7'h00;
   localparam logic [6:0] CODE_MAX = 7'h7F;

   // ---------------------------------------------------------------
   // decoded value
   // ---------------------------------------------------------------
   // 15 << 7 = 1920 needs 11 bits
   localparam int VALUE_W = 11;
   localparam logic [10:0] VALUE_MAX = 11'h780;
   localparam logic [10:0] VALUE_MIN = 11'h003;
   localparam logic [10:0] VALUE_RESET = 11'h000;

   // ---------------------------------------------------------------
   // physical scaling: one unit is 9.67 milliohm
   // ---------------------------------------------------------------
   localparam real LSB_MILLI_OHM = 9.67;
   localparam int LSB_MICRO_OHM_INT = int'(LSB_MILLI_OHM * 1000.0);
   localparam int WEIGHT_W = 14;
   localparam logic [13:0] LSB_MICRO_OHM = LSB_MICRO_OHM_INT[13:0];
   // 1920 * 9670 fits in 25 bits
   localparam int OHM_W = 25;
   localparam logic [24:0] OHM_RESET = 25'h0000000;

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   localparam int STEP_W = 4;
   localparam logic [3:0] STEP_LAST = 4'hA;
   localparam logic [3:0] STEP_RESET = 4'h0;

   typedef enum logic [1:0] {
      PRCD_IDLE = 2'b00,
      PRCD_EXPAND = 2'b01,
      PRCD_SCALE = 2'b10,
      PRCD_FINISH = 2'b11
   } prcd_state_t;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [10:0] prcd_decode(input logic [6:0] code);
      logic [10:0] mant;
      mant = {7'h00, code[MANT_MSB:MANT_LSB]};
      prcd_decode = mant << code[EXP_MSB:EXP_LSB];
   endfunction

   // codes whose mantissa top bit is clear above shift zero are redundant
   function automatic logic prcd_off_table(input logic [6:0] code);
      prcd_off_table = (code[EXP_MSB:EXP_LSB] != 3'h0) && !code[MANT_MSB];
   endfunction

endpackage

// ---- prcd_expand.sv ----
// registered expansion of the 7-bit resistance code into its linear value
`timescale 1ns/1ns
`default_nettype none
module prcd_expand
   import prcd_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic load,
   input wire logic [prcd_pkg::CODE_W-1:0] phase_res_code,
   output logic [prcd_pkg::VALUE_W-1:0] value_q
);

   logic [EXP_W-1:0] phase_res_exponent;
   logic [MANT_W-1:0] phase_res_mantissa;
   logic [VALUE_W-1:0] value_d;

   // ---------------------------------------------------------------
   // split and shift
   // ---------------------------------------------------------------
   assign phase_res_exponent = phase_res_code[EXP_MSB:EXP_LSB];
   assign phase_res_mantissa = phase_res_code[MANT_MSB:MANT_LSB];
   // full 11-bit width keeps 15 << 7 intact
   assign value_d = {7'h00, phase_res_mantissa} << phase_res_exponent;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         value_q <= VALUE_RESET;
      end else if (clk_en && load) begin
         value_q <= value_d;
      end
   end

endmodule
`default_nettype wire

// ---- prcd_decoder.sv ----
// phase resistance code decoder: code hold, expansion and micro-ohm scaling
//
// What this block does
// - holds resistance as one 7-bit code: 3-bit shift over 4-bit mantissa
// - digital value is the mantissa shifted left by the shift field
// - each unit of the value stands for 9.67 milliohm
// - code 0x7F decodes to the largest value, 1920, about 18.6 ohm
`timescale 1ns/1ns
`default_nettype none
module prcd_decoder
   import prcd_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic code_wr,
   input wire logic [prcd_pkg::CODE_W-1:0] code_wdata,
   output logic [prcd_pkg::CODE_W-1:0] phase_res_code,
   output logic [prcd_pkg::VALUE_W-1:0] phase_res_value,
   output logic [prcd_pkg::OHM_W-1:0] phase_to_center_resistance,
   output logic busy,
   output logic done,
   output logic below_min,
   output logic off_table,
   output logic at_max
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   prcd_state_t state_q;
   prcd_state_t state_d;
   logic [CODE_W-1:0] code_q;
   logic [VALUE_W-1:0] value_q;
   logic [VALUE_W-1:0] mplier_q;
   logic [OHM_W-1:0] mcand_q;
   logic [OHM_W-1:0] acc_q;
   logic [STEP_W-1:0] step_q;
   logic [OHM_W-1:0] ohm_q;
   logic busy_q;
   logic done_q;
   logic below_min_q;
   logic off_table_q;
   logic at_max_q;
   logic take_wr;
   logic expand_en;
   logic [VALUE_W-1:0] value_now;

   assign take_wr = clk_en && code_wr;
   assign expand_en = (state_q == PRCD_EXPAND);
   assign value_now = prcd_decode(code_q);

   // ---------------------------------------------------------------
   // configuration code hold
   // ---------------------------------------------------------------
   // the write port models the first motor configuration register;
   // a new write always wins, even in the middle of a conversion
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         code_q <= CODE_RESET;
      end else if (take_wr) begin
         code_q <= code_wdata;
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         PRCD_IDLE: begin
            state_d = PRCD_IDLE;
         end
         PRCD_EXPAND: begin
            state_d = PRCD_SCALE;
         end
         PRCD_SCALE: begin
            if (step_q == STEP_LAST) begin
               state_d = PRCD_FINISH;
            end
         end
         PRCD_FINISH: begin
            state_d = PRCD_IDLE;
         end
         default: begin
            state_d = PRCD_IDLE;
         end
      endcase
      if (code_wr) begin
         state_d = PRCD_EXPAND;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= PRCD_IDLE;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   // ---------------------------------------------------------------
   // linear value
   // ---------------------------------------------------------------
   prcd_expand u_expand (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .load(expand_en),
      .phase_res_code(code_q),
      .value_q(value_q)
   );

   // ---------------------------------------------------------------
   // scaling to micro-ohm
   // ---------------------------------------------------------------
   // serial shift-add saves an 11x14 multiplier; eleven steps at 10 MHz
   // are far below any rate at which the setting can change
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         step_q <= STEP_RESET;
      end else if (clk_en) begin
         if (state_q == PRCD_EXPAND) begin
            step_q <= STEP_RESET;
         end else if (state_q == PRCD_SCALE) begin
            step_q <= step_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mplier_q <= VALUE_RESET;
      end else if (clk_en) begin
         if (state_q == PRCD_EXPAND) begin
            mplier_q <= value_now;
         end else if (state_q == PRCD_SCALE) begin
            mplier_q <= {1'b0, mplier_q[VALUE_W-1:1]};
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mcand_q <= OHM_RESET;
      end else if (clk_en) begin
         if (state_q == PRCD_EXPAND) begin
            mcand_q <= {11'h000, LSB_MICRO_OHM};
         end else if (state_q == PRCD_SCALE) begin
            mcand_q <= {mcand_q[OHM_W-2:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= OHM_RESET;
      end else if (clk_en) begin
         if (state_q == PRCD_EXPAND) begin
            acc_q <= OHM_RESET;
         end else if (state_q == PRCD_SCALE && mplier_q[0]) begin
            acc_q <= acc_q + mcand_q;
         end
      end
   end

   // ---------------------------------------------------------------
   // results and status
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ohm_q <= OHM_RESET;
      end else if (clk_en && state_q == PRCD_FINISH && !code_wr) begin
         ohm_q <= acc_q;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
      end else if (clk_en) begin
         busy_q <= (state_d != PRCD_IDLE);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         done_q <= 1'b0;
      end else if (clk_en) begin
         done_q <= (state_q == PRCD_FINISH) && !code_wr;
      end
   end

   // flags judge the value of the code currently held; they update with done
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         below_min_q <= 1'b1;
      end else if (clk_en && state_q == PRCD_FINISH && !code_wr) begin
         // the device cannot refuse such a setting, it only reports it
         below_min_q <= (value_now < VALUE_MIN);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         off_table_q <= 1'b0;
      end else if (clk_en && state_q == PRCD_FINISH && !code_wr) begin
         off_table_q <= prcd_off_table(code_q);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         at_max_q <= 1'b0;
      end else if (clk_en && state_q == PRCD_FINISH && !code_wr) begin
         at_max_q <= (code_q == CODE_MAX) && (value_now == VALUE_MAX);
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign phase_res_code = code_q;
   assign phase_res_value = value_q;
   assign phase_to_center_resistance = ohm_q;
   assign busy = busy_q;
   assign done = done_q;
   assign below_min = below_min_q;
   assign off_table = off_table_q;
   assign at_max = at_max_q;

endmodule
`default_nettype wire

// ---- prcd_decoder_asserts.sv ----
// checker for the phase resistance code decoder
`timescale 1ns/1ns
`default_nettype none
module prcd_decoder_asserts (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic code_wr,
   input wire logic [6:0] code_wdata,
   input wire logic [6:0] phase_res_code,
   input wire logic [10:0] phase_res_value,
   input wire logic [24:0] phase_to_center_resistance,
   input wire logic busy,
   input wire logic done,
   input wire logic at_max
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ---------------------------------------------------------------
   // conversion steps
   // ---------------------------------------------------------------
   sequence s_go; clk_en && code_wr; endsequence
   sequence s_run; clk_en && !code_wr; endsequence
   property p_code; s_go |=> phase_res_code == $past(code_wdata); endproperty
   a_code: assert property (p_code) else $error("held code differs");
   property p_busy; s_go |=> busy; endproperty
   a_busy: assert property (p_busy) else $error("busy missing");
   property p_lat; s_go ##1 s_run[*8] ##1 s_run[*5] |=> done; endproperty
   a_lat: assert property (p_lat) else $error("done late");
   property p_pulse; done && clk_en |=> !done; endproperty
   a_pulse: assert property (p_pulse) else $error("done too long");
   property p_value;
      done |-> phase_res_value == (11'(phase_res_code[3:0]) << phase_res_code[6:4]);
   endproperty
   a_value: assert property (p_value) else $error("bad value");
   property p_ohm;
      done |-> phase_to_center_resistance == 25'(phase_res_value) * 25'd9670;
   endproperty
   a_ohm: assert property (p_ohm) else $error("bad weight");
   property p_max; done |-> at_max == (phase_res_code == 7'h7F); endproperty
   a_max: assert property (p_max) else $error("bad max flag");
   property p_maxv; done && at_max |-> phase_res_value == 11'h780; endproperty
   a_maxv: assert property (p_maxv) else $error("bad max value");
endmodule
bind prcd_decoder prcd_decoder_asserts u_chk (.clock(clock), .rst_n(rst_n),
   .clk_en(clk_en), .code_wr(code_wr), .code_wdata(code_wdata),
   .phase_res_code(phase_res_code), .phase_res_value(phase_res_value),
   .phase_to_center_resistance(phase_to_center_resistance), .busy(busy),
   .done(done), .at_max(at_max));
`default_nettype wire

// ---- phase_resistance_code_decoder_tb_top.sv ----
// self-checking testbench for the phase resistance code decoder
`timescale 1ns/1ns
`default_nettype none
module phase_resistance_code_decoder_tb_top;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic code_wr = 1'b0;
   logic [6:0] code_wdata = 7'h00;
   logic [6:0] phase_res_code;
   logic [10:0] phase_res_value;
   logic [24:0] phase_to_center_resistance;
   logic busy, done, below_min, off_table, at_max;
   int n_fail = 0;
   int samples_checked = 0;
   int n;
   always #50 clock = ~clock;
   prcd_decoder DUT (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .code_wr(code_wr),
      .code_wdata(code_wdata), .phase_res_code(phase_res_code),
      .phase_res_value(phase_res_value),
      .phase_to_center_resistance(phase_to_center_resistance), .busy(busy),
      .done(done), .below_min(below_min), .off_table(off_table), .at_max(at_max));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [6:0] c);
      @(posedge clock);
      code_wr <= 1'b1;
      code_wdata <= c;
      @(posedge clock);
      code_wr <= 1'b0;
   endtask
   // bounded so a lost done cannot hang the run
   task automatic wait_done(output int cnt);
      cnt = 0;
      while (cnt < 40) begin
         @(posedge clock);
         cnt++;
         #1;
         if (done === 1'b1) return;
      end
      n_fail++;
      conclude();
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      chk(phase_res_code, 0);
      chk(phase_res_value, 0);
      chk(phase_to_center_resistance, 0);
      chk({busy, done, below_min, off_table, at_max}, 5'b00100);
   endtask
   task automatic t_table;
      logic [6:0] codes [8] = '{7'h7F, 7'h18, 7'h02, 7'h03, 7'h28, 7'h5A, 7'h0F, 7'h10};
      logic [10:0] v;
      foreach (codes[i]) begin
         v = 11'(codes[i][3:0]) << codes[i][6:4];
         wr(codes[i]);
         wait_done(n);
         chk(n, 13);
         chk(phase_res_code, codes[i]);
         chk(phase_res_value, v);
         chk(phase_to_center_resistance, 25'(v) * 25'd9670);
         chk(at_max, codes[i] == 7'h7F);
         chk(below_min, v < 11'd3);
         chk(off_table, codes[i][6:4] != 3'h0 && !codes[i][3]);
         chk(busy, 0);
         @(posedge clock);
         #1;
         chk(done, 0);
      end
   endtask
   task automatic t_restart;
      wr(7'h7F);
      repeat (4) @(posedge clock);
      wr(7'h03);
      wait_done(n);
      chk(n, 13);
      chk({at_max, below_min, phase_res_value}, {2'b00, 11'd3});
   endtask
   task automatic t_clk_en;
      fork
         begin
            wr(7'h4A);
            wait_done(n);
         end
         begin
            repeat (4) @(posedge clock);
            clk_en <= 1'b0;
            repeat (4) @(posedge clock);
            clk_en <= 1'b1;
         end
      join
      chk(n, 17);
      chk(phase_to_center_resistance, 25'd1547200);
   endtask
   // reset in mid-conversion: outputs drop to idle, then a fresh write converts
   task automatic t_mid_reset;
      wr(7'h5A);
      repeat (3) @(posedge clock);
      rst_n <= 1'b0;
      @(posedge clock);
      #1;
      t_reset();
      @(posedge clock);
      rst_n <= 1'b1;
      wr(7'h18);
      wait_done(n);
      chk(n, 13);
      chk(phase_res_value, 16);
      chk(phase_to_center_resistance, 25'd154720);
   endtask
   initial begin
      // the declared low reset makes no edge, so check only after a clocked reset
      @(posedge clock);
      #1;
      t_reset();
      @(posedge clock);
      rst_n <= 1'b1;
      t_table();
      t_restart();
      t_clk_en();
      t_mid_reset();
      conclude();
   end
endmodule
`default_nettype wire
